// ### common/port_timer_pkg.sv
/*
  Shared constants and carriers for the parallel port, handshake and interval timer block.
  Assumes an 8-bit processor bus with four register-select lines and one system clock.
*/
package port_timer_pkg;

  // ----------------------------------------------------------------------
  // Register select codes
  // ----------------------------------------------------------------------
  localparam logic [3:0] RS_PORT_B    = 4'h0;
  localparam logic [3:0] RS_PORT_A    = 4'h1;
  localparam logic [3:0] RS_DIR_B     = 4'h2;
  localparam logic [3:0] RS_DIR_A     = 4'h3;
  localparam logic [3:0] RS_T1_CNT_LO = 4'h4;
  localparam logic [3:0] RS_T1_CNT_HI = 4'h5;
  localparam logic [3:0] RS_T1_LAT_LO = 4'h6;
  localparam logic [3:0] RS_T1_LAT_HI = 4'h7;
  localparam logic [3:0] RS_AUX       = 4'hB;
  localparam logic [3:0] RS_PCR       = 4'hC;
  localparam logic [3:0] RS_FLAGS     = 4'hD;
  localparam logic [3:0] RS_ENABLE    = 4'hE;
  localparam logic [3:0] RS_PORT_A_NH = 4'hF;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int AUX_A_LATCH  = 0;
  localparam int AUX_FREE_RUN = 6;
  localparam int AUX_TIMER_PIN = 7;
  localparam int PCR_A_EDGE   = 0;
  localparam int PCR_A_MODE   = 1;
  localparam int PCR_B_EDGE   = 4;
  localparam int PCR_B_MODE   = 5;
  localparam int FLAG_A_CTRL  = 1;
  localparam int FLAG_B_CTRL  = 4;
  localparam int FLAG_TIMER   = 6;
  localparam int FLAG_ANY     = 7;
  localparam int ENABLE_SET   = 7;
  localparam int TOP_BIT      = 7;

  // Control-output modes, three bits each
  localparam logic [2:0] CTRL_HANDSHAKE = 3'h4;
  localparam logic [2:0] CTRL_PULSE     = 3'h5;
  localparam logic [2:0] CTRL_LOW       = 3'h6;
  localparam logic [2:0] CTRL_HIGH      = 3'h7;

  localparam logic [15:0] COUNT_ONE = 16'h0001;

  // ----------------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic       sel;
    logic       rd;
    logic [3:0] rs;
    logic [7:0] wdata;
  } bus_req_t;

  typedef struct packed {
    logic [7:0]  out_a;
    logic [7:0]  out_b;
    logic [7:0]  dir_a;
    logic [7:0]  dir_b;
    logic [7:0]  aux;
    logic [7:0]  peripheral_control;
    logic [6:0]  ien;
    logic [6:0]  flags;
    logic [15:0] t_latch;
    logic [15:0] t_cnt;
    logic        t_armed;
    logic        t_out;
    logic        a_hs;
    logic        b_hs;
    logic        a_pulse;
    logic        b_pulse;
    logic        a_prev;
    logic        b_prev;
    logic [7:0]  rdata;
    logic        rd_oe;
  } state_t;

endpackage

// ### core/port_timer.sv
/*
  Two 8-bit peripheral ports with direction control, read/write handshake on the control lines,
  a capture FIFO for latched port A data, and a 16-bit interval timer with one-shot and
  free-running modes driving the top port B pin.
  Assumes all inputs are synchronous to ref_clk and that a selected bus cycle lasts one clock.
*/
// Contract
// - Reading either port puts its input register value on the data bus.
// - With latching off, port A reads return live pin levels.
// - With latching on, active control edge captures port A pins and holds them.
// - Once every queued capture is read, port A reads follow the pins again.
// - Port B output bits read back the stored output register bit.
// - Port A output bits read back the sensed pin level.
// - Output register writes on input bits are stored but never drive pins.
// - Port B handshakes writes only; port A handshakes reads and writes.
// - Read handshake on port A: data ready in, data taken out.
// - A data-ready edge sets a pollable flag that may raise interrupt.
// - Data taken is pulse or level; read lowers it, next edge raises it.
// - Timer: two 8-bit latches feed a 16-bit counter decrementing every clock.
// - Low counter write stores low latch; high write loads latch and counter.
// - Counting starts the clock after the high counter write.
// - One-shot mode flags once at zero, then stays quiet until rewritten.
// - One-shot with pin output: pin low after load, high at zero.
// - Timer flag clears on high counter write or low counter read.
// - Free-run: at zero set flag, toggle pin, reload all 16 bits.
// - Free-run flag re-arms itself; flag register write also clears it.
// - Each high counter write restarts the period, so rewrites prevent time-out.
// - Latch-only writes leave the running count alone, shaping next period.
// - Top port B pin carries timer output only when its direction and aux bit set.
// - Interrupt output pulls low while any enabled flag is set.
// - Reset clears all but timer latches and counter, sets timer and handshake outputs high; pins input, interrupts off.
`timescale 1ns/100ps

// ------------------------------------------------------------------------
// Capture FIFO
// ------------------------------------------------------------------------
module capture_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input  wire logic             ref_clk,
  input  wire logic             reset_n,
  // Filling side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Draining side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0]   count;
  } fifo_state_t;

  fifo_state_t      st_q;
  fifo_state_t      st_d;
  logic [WIDTH-1:0] mem [DEPTH];
  logic             push;
  logic             pop;

  // Honest flags straight from the occupancy count
  assign in_ready  = (st_q.count != (AW+1)'(DEPTH));
  assign out_valid = (st_q.count != '0);
  assign out_data  = mem[st_q.rd_ptr];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  // Pointer and count update
  always_comb begin
    st_d = st_q;
    if (push) begin
      st_d.wr_ptr = st_q.wr_ptr + AW'(1);
    end
    if (pop) begin
      st_d.rd_ptr = st_q.rd_ptr + AW'(1);
    end
    st_d.count = st_q.count + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge ref_clk) begin
    st_q <= reset_n ? st_d : '0;
  end

  // Storage needs no reset; occupancy decides what is visible
  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem[st_q.wr_ptr] <= in_data;
    end
  end
endmodule

// ------------------------------------------------------------------------
// Port, handshake and timer top
// ------------------------------------------------------------------------
module port_timer #(
  parameter int FIFO_DEPTH = 4
) (
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       reset_n,
  // Processor bus
  input  wire logic       select_high,
  input  wire logic       select_low_n,
  input  wire logic       read_not_write,
  input  wire logic [3:0] register_select,
  input  wire logic [7:0] data_in,
  output logic [7:0]      data_out,
  output logic            data_oe,
  output logic            irq_n_out,
  output logic            irq_oe,
  // Port A
  input  wire logic [7:0] port_a_pins_in,
  output logic [7:0]      port_a_pins_out,
  output logic [7:0]      port_a_pins_oe,
  input  wire logic       a_ctrl_in,
  output logic            a_ctrl_out,
  output logic            a_capture_ready,
  // Port B
  input  wire logic [7:0] port_b_pins_in,
  output logic [7:0]      port_b_pins_out,
  output logic [7:0]      port_b_pins_oe,
  input  wire logic       b_ctrl_in,
  output logic            b_ctrl_out
);

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  port_timer_pkg::state_t   st_q;
  port_timer_pkg::state_t   st_d;
  port_timer_pkg::bus_req_t req;
  logic                     wr_en;
  logic                     rd_en;
  logic                     wr_hi;
  logic                     a_edge;
  logic                     b_edge;
  logic                     timeout;
  logic                     free_run;
  logic                     irq_any;
  logic                     a_latch_on;
  logic                     a_port_rd;
  logic [7:0]               a_read_val;
  logic [7:0]               b_read_val;
  logic [2:0]               a_mode;
  logic [2:0]               b_mode;
  logic                     fifo_in_valid;
  logic                     fifo_in_ready;
  logic                     fifo_out_valid;
  logic                     fifo_pop;
  logic [7:0]               fifo_out_data;

  // ----------------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------------
  // Both selects must agree; an access lasts exactly one sampled edge
  assign req   = '{sel:   select_high & ~select_low_n,
                   rd:    read_not_write,
                   rs:    register_select,
                   wdata: data_in};
  assign wr_en = req.sel & ~req.rd;
  assign rd_en = req.sel & req.rd;
  assign wr_hi = wr_en & (req.rs == port_timer_pkg::RS_T1_CNT_HI);

  // ----------------------------------------------------------------------
  // Control line edges and modes
  // ----------------------------------------------------------------------
  // Edge select bit set means rising; previous sample resets low, so a
  // line idling high cannot fake a falling edge just after reset
  assign a_edge = st_q.peripheral_control[port_timer_pkg::PCR_A_EDGE] ? (a_ctrl_in & ~st_q.a_prev)
                                                       : (~a_ctrl_in & st_q.a_prev);
  assign b_edge = st_q.peripheral_control[port_timer_pkg::PCR_B_EDGE] ? (b_ctrl_in & ~st_q.b_prev)
                                                       : (~b_ctrl_in & st_q.b_prev);
  assign a_mode = st_q.peripheral_control[port_timer_pkg::PCR_A_MODE +: 3];
  assign b_mode = st_q.peripheral_control[port_timer_pkg::PCR_B_MODE +: 3];

  // Timer state seen by the update logic
  assign free_run = st_q.aux[port_timer_pkg::AUX_FREE_RUN];
  assign timeout  = st_q.t_armed & (st_q.t_cnt == '0);

  // ----------------------------------------------------------------------
  // Port A capture queue
  // ----------------------------------------------------------------------
  // A slow reader would lose samples with a single latch; the queue keeps
  // up to its depth, and a full queue drops further captures
  assign a_latch_on    = st_q.aux[port_timer_pkg::AUX_A_LATCH];
  assign fifo_in_valid = a_edge & a_latch_on;
  assign a_port_rd     = rd_en & ((req.rs == port_timer_pkg::RS_PORT_A) |
                                  (req.rs == port_timer_pkg::RS_PORT_A_NH));
  assign fifo_pop      = a_port_rd & a_latch_on & fifo_out_valid;

  capture_fifo #(
    .WIDTH (8),
    .DEPTH (FIFO_DEPTH)
  ) i_capture_fifo (
    .ref_clk   (ref_clk),
    .reset_n   (reset_n),
    .in_valid  (fifo_in_valid),
    .in_ready  (fifo_in_ready),
    .in_data   (port_a_pins_in),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_pop),
    .out_data  (fifo_out_data)
  );

  assign a_capture_ready = fifo_out_valid;

  // Held sample while latching is on and one is queued, live pins otherwise
  assign a_read_val = (a_latch_on & fifo_out_valid) ? fifo_out_data
                                                    : port_a_pins_in;

  // ----------------------------------------------------------------------
  // Pin drive and port B read-back, per bit
  // ----------------------------------------------------------------------
  for (genvar i = 0; i < 8; i++) begin : g_pins
    assign port_a_pins_out[i] = st_q.out_a[i];
    assign port_a_pins_oe[i]  = st_q.dir_a[i];
    assign port_b_pins_oe[i]  = st_q.dir_b[i];
    assign b_read_val[i]      = st_q.dir_b[i] ? st_q.out_b[i] : port_b_pins_in[i];
    if (i == port_timer_pkg::TOP_BIT) begin : g_top
      // Timer takes the pin only when both enables agree
      assign port_b_pins_out[i] = (st_q.dir_b[i] & st_q.aux[port_timer_pkg::AUX_TIMER_PIN])
                                  ? st_q.t_out : st_q.out_b[i];
    end else begin : g_plain
      assign port_b_pins_out[i] = st_q.out_b[i];
    end
  end

  // ----------------------------------------------------------------------
  // Bus and interrupt outputs
  // ----------------------------------------------------------------------
  assign data_out  = st_q.rdata;
  assign data_oe   = st_q.rd_oe;
  // Open drain: only ever pulls low, enable carries the request
  assign irq_any   = |(st_q.flags & st_q.ien);
  assign irq_n_out = 1'b0;
  assign irq_oe    = irq_any;

  // ----------------------------------------------------------------------
  // Control line outputs
  // ----------------------------------------------------------------------
  // Input modes leave the line idling high
  always_comb begin
    case (a_mode)
      port_timer_pkg::CTRL_HANDSHAKE: begin
        a_ctrl_out = st_q.a_hs;
      end
      port_timer_pkg::CTRL_PULSE: begin
        a_ctrl_out = ~st_q.a_pulse;
      end
      port_timer_pkg::CTRL_LOW: begin
        a_ctrl_out = 1'b0;
      end
      port_timer_pkg::CTRL_HIGH: begin
        a_ctrl_out = 1'b1;
      end
      default: begin
        a_ctrl_out = 1'b1;
      end
    endcase
  end

  // Port B only ever announces data, never takes it
  always_comb begin
    case (b_mode)
      port_timer_pkg::CTRL_HANDSHAKE: begin
        b_ctrl_out = st_q.b_hs;
      end
      port_timer_pkg::CTRL_PULSE: begin
        b_ctrl_out = ~st_q.b_pulse;
      end
      port_timer_pkg::CTRL_LOW: begin
        b_ctrl_out = 1'b0;
      end
      port_timer_pkg::CTRL_HIGH: begin
        b_ctrl_out = 1'b1;
      end
      default: begin
        b_ctrl_out = 1'b1;
      end
    endcase
  end

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  // Order matters: reads and writes clear first, events set last, so a
  // flag event in the same cycle as its clear is never lost
  always_comb begin
    st_d         = st_q;
    st_d.a_prev  = a_ctrl_in;
    st_d.b_prev  = b_ctrl_in;
    st_d.a_pulse = 1'b0;
    st_d.b_pulse = 1'b0;
    st_d.rd_oe   = rd_en;
    st_d.t_cnt   = st_q.t_cnt - port_timer_pkg::COUNT_ONE;

    // Time-out; a high counter write below overrides the reload
    if (timeout) begin
      if (free_run) begin
        st_d.t_out = ~st_q.t_out;
        st_d.t_cnt = st_q.t_latch;
      end else begin
        st_d.t_armed = 1'b0;
        st_d.t_out   = 1'b1;
      end
    end

    // Reads: capture data and apply read side effects
    if (rd_en) begin
      case (req.rs)
        port_timer_pkg::RS_PORT_B: begin
          st_d.rdata = b_read_val;
          st_d.flags[port_timer_pkg::FLAG_B_CTRL] = 1'b0;
        end
        port_timer_pkg::RS_PORT_A: begin
          st_d.rdata = a_read_val;
          st_d.flags[port_timer_pkg::FLAG_A_CTRL] = 1'b0;
          if (a_mode == port_timer_pkg::CTRL_HANDSHAKE) begin
            st_d.a_hs = 1'b0;
          end
          st_d.a_pulse = (a_mode == port_timer_pkg::CTRL_PULSE);
        end
        port_timer_pkg::RS_PORT_A_NH: begin
          st_d.rdata = a_read_val;
        end
        port_timer_pkg::RS_DIR_B: begin
          st_d.rdata = st_q.dir_b;
        end
        port_timer_pkg::RS_DIR_A: begin
          st_d.rdata = st_q.dir_a;
        end
        port_timer_pkg::RS_T1_CNT_LO: begin
          st_d.rdata = st_q.t_cnt[7:0];
          st_d.flags[port_timer_pkg::FLAG_TIMER] = 1'b0;
        end
        port_timer_pkg::RS_T1_CNT_HI: begin
          st_d.rdata = st_q.t_cnt[15:8];
        end
        port_timer_pkg::RS_T1_LAT_LO: begin
          st_d.rdata = st_q.t_latch[7:0];
        end
        port_timer_pkg::RS_T1_LAT_HI: begin
          st_d.rdata = st_q.t_latch[15:8];
        end
        port_timer_pkg::RS_AUX: begin
          st_d.rdata = st_q.aux;
        end
        port_timer_pkg::RS_PCR: begin
          st_d.rdata = st_q.peripheral_control;
        end
        port_timer_pkg::RS_FLAGS: begin
          st_d.rdata = {irq_any, st_q.flags};
        end
        port_timer_pkg::RS_ENABLE: begin
          st_d.rdata = {1'b1, st_q.ien};
        end
        default: begin
          st_d.rdata = '0;
        end
      endcase
    end

    // Writes
    if (wr_en) begin
      case (req.rs)
        port_timer_pkg::RS_PORT_B: begin
          st_d.out_b = req.wdata;
          st_d.flags[port_timer_pkg::FLAG_B_CTRL] = 1'b0;
          if (b_mode == port_timer_pkg::CTRL_HANDSHAKE) begin
            st_d.b_hs = 1'b0;
          end
          st_d.b_pulse = (b_mode == port_timer_pkg::CTRL_PULSE);
        end
        port_timer_pkg::RS_PORT_A: begin
          st_d.out_a = req.wdata;
          st_d.flags[port_timer_pkg::FLAG_A_CTRL] = 1'b0;
          if (a_mode == port_timer_pkg::CTRL_HANDSHAKE) begin
            st_d.a_hs = 1'b0;
          end
          st_d.a_pulse = (a_mode == port_timer_pkg::CTRL_PULSE);
        end
        port_timer_pkg::RS_PORT_A_NH: begin
          st_d.out_a = req.wdata;
        end
        port_timer_pkg::RS_DIR_B: begin
          st_d.dir_b = req.wdata;
        end
        port_timer_pkg::RS_DIR_A: begin
          st_d.dir_a = req.wdata;
        end
        port_timer_pkg::RS_T1_CNT_LO, port_timer_pkg::RS_T1_LAT_LO: begin
          st_d.t_latch[7:0] = req.wdata;
        end
        port_timer_pkg::RS_T1_CNT_HI: begin
          // Restart: supersedes a time-out's reload and pin change in this cycle, though its flag still sets
          st_d.t_latch[15:8] = req.wdata;
          st_d.t_cnt         = {req.wdata, st_q.t_latch[7:0]};
          st_d.t_armed       = 1'b1;
          st_d.t_out         = 1'b0;
          st_d.flags[port_timer_pkg::FLAG_TIMER] = 1'b0;
        end
        port_timer_pkg::RS_T1_LAT_HI: begin
          st_d.t_latch[15:8] = req.wdata;
        end
        port_timer_pkg::RS_AUX: begin
          st_d.aux = req.wdata;
        end
        port_timer_pkg::RS_PCR: begin
          st_d.peripheral_control = req.wdata;
        end
        port_timer_pkg::RS_FLAGS: begin
          st_d.flags = st_q.flags & ~req.wdata[6:0];
        end
        port_timer_pkg::RS_ENABLE: begin
          if (req.wdata[port_timer_pkg::ENABLE_SET]) begin
            st_d.ien = st_q.ien | req.wdata[6:0];
          end else begin
            st_d.ien = st_q.ien & ~req.wdata[6:0];
          end
        end
        default: begin
        end
      endcase
    end

    // Events set their flags last so that they win over clears
    if (timeout) begin
      st_d.flags[port_timer_pkg::FLAG_TIMER] = 1'b1;
    end
    if (a_edge) begin
      st_d.flags[port_timer_pkg::FLAG_A_CTRL] = 1'b1;
      st_d.a_hs = 1'b1;
    end
    if (b_edge) begin
      st_d.flags[port_timer_pkg::FLAG_B_CTRL] = 1'b1;
      st_d.b_hs = 1'b1;
    end

    // Reset keeps the timer latch and count; outputs idle high, pins input
    if (!reset_n) begin
      st_d         = '0;
      st_d.t_latch = st_q.t_latch;
      st_d.t_cnt   = st_q.t_cnt;
      st_d.t_out   = 1'b1;
      st_d.a_hs    = 1'b1;
      st_d.b_hs    = 1'b1;
    end
  end

  // State register
  always_ff @(posedge ref_clk) begin
    st_q <= st_d;
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  a_high_write_load: assert property (@(posedge ref_clk) disable iff (!reset_n)
    wr_hi |=> (st_q.t_cnt[15:8] == $past(data_in)))
    else $error("high counter write did not load the count");

  a_count_step: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (st_q.t_armed && !wr_hi && (st_q.t_cnt != '0))
    |=> (st_q.t_cnt == $past(st_q.t_cnt) - port_timer_pkg::COUNT_ONE))
    else $error("armed count did not step down by one");

  a_timeout_flag: assert property (@(posedge ref_clk) disable iff (!reset_n)
    timeout |=> st_q.flags[port_timer_pkg::FLAG_TIMER])
    else $error("time-out did not set the timer flag");

  a_oneshot_pin_low: assert property (@(posedge ref_clk) disable iff (!reset_n)
    wr_hi |=> !st_q.t_out)
    else $error("timer output not low after high counter write");

  a_oneshot_disarm: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (timeout && !free_run && !wr_hi) |=> !st_q.t_armed)
    else $error("one-shot timer still armed after time-out");

  a_free_run_reload: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (timeout && free_run && !wr_hi) |=> (st_q.t_cnt == $past(st_q.t_latch)))
    else $error("free-running timer did not reload from the latch");

  a_read_clears_flag: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (rd_en && (req.rs == port_timer_pkg::RS_PORT_A) && !a_edge)
    |=> !st_q.flags[port_timer_pkg::FLAG_A_CTRL])
    else $error("port A read left the control flag set");

  // Main scenarios worth seeing at least once
  c_capture_push: cover property (@(posedge ref_clk) disable iff (!reset_n)
    fifo_in_valid && fifo_in_ready);
  c_oneshot_timeout: cover property (@(posedge ref_clk) disable iff (!reset_n)
    timeout && !free_run);
  c_free_run_reload: cover property (@(posedge ref_clk) disable iff (!reset_n)
    timeout && free_run);
  c_capture_full: cover property (@(posedge ref_clk) disable iff (!reset_n)
    !fifo_in_ready);
endmodule

// ### dv/periph_model.sv
/*
  Behavioural peripheral on the two ports: resolves each pin from the block's drive and the
  peripheral's own levels. Assumes the bench sets the peripheral levels and strobe.
*/
`timescale 1ns/100ps
module periph_model (
  // Block drive
  input  wire logic [7:0] a_out,
  input  wire logic [7:0] a_oe,
  input  wire logic [7:0] b_out,
  input  wire logic [7:0] b_oe,
  // Peripheral levels
  input  wire logic [7:0] dev_a,
  input  wire logic [7:0] dev_b,
  // Resolved pins
  output logic [7:0]      a_pin,
  output logic [7:0]      b_pin
);
  // Block wins where it drives, else the peripheral level shows
  assign a_pin = (a_oe & a_out) | (~a_oe & dev_a);
  assign b_pin = (b_oe & b_out) | (~b_oe & dev_b);
endmodule

// ### dv/parallel_port_handshake_timer_bench.sv
/*
  Register-level bench for the port and timer block.
  Assumes a bus cycle is taken on one edge and read data is settled after that edge.
*/
`timescale 1ns/100ps
module parallel_port_handshake_timer_bench;
  logic ref_clk = 1'b0, reset_n = 1'b0, sel = 1'b0, rnw = 1'b1, a_strobe = 1'b0;
  logic [3:0] rs = 4'h0;
  logic a_ho;
  logic [7:0] wd = 8'h00, dev_a = 8'h00, dev_b = 8'h00, rd, dout, a_o, a_e, b_o, b_e, a_p, b_p;
  int failures = 0, tests_run = 0, n;
  port_timer i_port_timer (.ref_clk(ref_clk), .reset_n(reset_n), .select_high(sel),
    .select_low_n(1'b0), .read_not_write(rnw), .register_select(rs), .data_in(wd),
    .data_out(dout), .data_oe(), .irq_n_out(), .irq_oe(), .port_a_pins_in(a_p),
    .port_a_pins_out(a_o), .port_a_pins_oe(a_e), .a_ctrl_in(a_strobe), .a_ctrl_out(a_ho),
    .a_capture_ready(), .port_b_pins_in(b_p), .port_b_pins_out(b_o), .port_b_pins_oe(b_e),
    .b_ctrl_in(1'b0), .b_ctrl_out());
  periph_model i_periph_model (.a_out(a_o), .a_oe(a_e), .b_out(b_o), .b_oe(b_e),
    .dev_a(dev_a), .dev_b(dev_b), .a_pin(a_p), .b_pin(b_p));
  // ----------------------------------------------------------------------
  // Bus tasks
  // ----------------------------------------------------------------------
  initial begin
    forever #2 ref_clk = ~ref_clk;
  end
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    sel <= 1'b1; rnw <= 1'b0; rs <= a; wd <= d;
    @(posedge ref_clk);
    sel <= 1'b0; rnw <= 1'b1;
    #1;
  endtask
  task automatic rdr(input logic [3:0] a);
    @(posedge ref_clk);
    sel <= 1'b1; rnw <= 1'b1; rs <= a;
    @(posedge ref_clk);
    sel <= 1'b0;
    #1 rd = dout;
  endtask
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      failures++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic end_of_test;
    if (failures == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  initial begin
    repeat (8) @(posedge ref_clk);
    reset_n <= 1'b1;
    rdr(port_timer_pkg::RS_DIR_B); chk("dir_b reset", 8'h00, rd);
    chk("b oe reset", 8'h00, b_e);
    dev_b <= 8'hC3; wr(port_timer_pkg::RS_PORT_B, 8'h5A);
    chk("b oe on input", 8'h00, b_e);
    wr(port_timer_pkg::RS_DIR_B, 8'h0F);
    chk("b oe", 8'h0F, b_e);
    chk("b out", 8'h0A, b_o & 8'h0F);
    rdr(port_timer_pkg::RS_PORT_B); chk("port b read", 8'hCA, rd);
    // Live port A with latching off, then a captured sample
    dev_a <= 8'h3C; rdr(port_timer_pkg::RS_PORT_A_NH); chk("a live", 8'h3C, rd);
    wr(port_timer_pkg::RS_PCR, 8'h01); wr(port_timer_pkg::RS_AUX, 8'h01);
    dev_a <= 8'h11; @(posedge ref_clk) a_strobe <= 1'b1;
    @(posedge ref_clk) dev_a <= 8'h22;
    rdr(port_timer_pkg::RS_PORT_A_NH); chk("a latched", 8'h11, rd);
    rdr(port_timer_pkg::RS_PORT_A_NH); chk("a transparent", 8'h22, rd);
    rdr(port_timer_pkg::RS_FLAGS); chk("a flag", 8'h02, rd & 8'h02);
    // Read handshake: a read lowers data taken, the next ready edge raises it
    wr(port_timer_pkg::RS_PCR, 8'h09); rdr(port_timer_pkg::RS_PORT_A);
    chk("data taken low", 8'h00, {7'h00, a_ho});
    a_strobe <= 1'b0; @(posedge ref_clk) a_strobe <= 1'b1;
    repeat (2) @(posedge ref_clk);
    #1 chk("data taken high", 8'h01, {7'h00, a_ho});
    // One-shot with top pin pulse; period of 6 counts
    wr(port_timer_pkg::RS_DIR_B, 8'h80); wr(port_timer_pkg::RS_AUX, 8'h80);
    wr(port_timer_pkg::RS_T1_CNT_LO, 8'h06); wr(port_timer_pkg::RS_T1_CNT_HI, 8'h00);
    #1 chk("pin low", 8'h00, {7'h00, b_o[7]});
    n = 0;
    while (b_o[7] !== 1'b1 && n < 40) begin
      @(posedge ref_clk); #1 n++;
    end
    // Six steps down, time-out acts on the edge after zero is reached
    chk("timeout seen", 8'h01, {7'h00, n == 7});
    rdr(port_timer_pkg::RS_FLAGS); chk("t flag", 8'h40, rd & 8'h40);
    rdr(port_timer_pkg::RS_T1_CNT_LO);
    rdr(port_timer_pkg::RS_FLAGS); chk("t flag clear", 8'h00, rd & 8'h40);
    repeat (80) @(posedge ref_clk);
    rdr(port_timer_pkg::RS_FLAGS); chk("no second flag", 8'h00, rd & 8'h40);
    end_of_test();
  end
endmodule
